/* dv/cap_src.sv */
// Pulse source model for the capture input pin
module cap_src (
	input wire logic i_mclk,
	input wire logic i_go,
	input wire logic [7:0] i_width,
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left;
	initial begin
		o_pin = 1'h0;
		left = 8'h00;
	end
	// Idle low between pulses; edges always at least one cycle apart
	always @(posedge i_mclk) begin
		if (i_go) begin
			o_pin <= 1'h1;
			left <= i_width;
		end else if (left > 8'h01) begin
			left <= left - 8'h01;
		end else begin
			o_pin <= 1'h0;
			left <= 8'h00;
		end
	end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the timer X/Y connection block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import txy_pkg::*;
	typedef struct packed {
		logic wr;
		logic [19:0] a;
		logic [7:0] wd;
		logic [7:0] rd;
		logic err;
	} row_t;
	localparam logic [19:0] A_CAP = {IDX_CAP_CTRL, 2'h0};
	localparam logic [19:0] A_BANK = {IDX_BANK_SEL, 2'h0};
	localparam logic [19:0] A_XY = {IDX_XY_CLK, 2'h0};
	localparam logic [19:0] A_STAT = {IDX_IRQ_STAT, 2'h0};
	localparam logic [19:0] A_MASK = {IDX_IRQ_MASK, 2'h0};
	localparam logic [19:0] A_RISE = 20'h3ffc8;
	localparam logic [19:0] A_FALL = 20'h3ffcc;
	// Reserved bits always written as zero
	localparam row_t ROWS [16] = '{
		'{1'h1, A_XY, 8'h30, 8'h00, 1'h0},
		'{1'h0, A_XY, 8'h00, 8'h30, 1'h0},
		'{1'h1, A_XY, 8'h20, 8'h00, 1'h0},
		'{1'h0, A_XY, 8'h00, 8'h20, 1'h0},
		'{1'h0, 20'h3ffc0, 8'h00, 8'h50, 1'h0},
		'{1'h0, 20'h3ffdc, 8'h00, 8'h57, 1'h0},
		'{1'h1, A_BANK, 8'h80, 8'h00, 1'h0},
		'{1'h0, A_BANK, 8'h00, 8'h80, 1'h0},
		'{1'h0, 20'h3ffc0, 8'h00, 8'hd0, 1'h0},
		'{1'h0, 20'h3ffd0, 8'h00, 8'hd4, 1'h0},
		'{1'h0, 20'h3ffd4, 8'h00, 8'h00, 1'h1},
		'{1'h1, A_BANK, 8'h00, 8'h00, 1'h0},
		'{1'h0, 20'h3fff4, 8'h00, 8'h00, 1'h1},
		'{1'h0, A_RISE, 8'h00, 8'h00, 1'h0},
		'{1'h1, A_RISE, 8'hff, 8'h00, 1'h0},
		'{1'h0, A_RISE, 8'h00, 8'h00, 1'h0}
	};
	localparam logic [19:0] RST_A [7] = '{A_CAP, A_BANK, A_XY, A_RISE, A_FALL, A_STAT, A_MASK};
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, pin, ymatch, go;
	logic arm, xsel, ysel, casc, cmc, cpulse, irq;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd, er;
	logic [7:0] xcnt, width, wrd;
	logic [2:0] xsrc, ysrc;
	win_req_t wreq;
	int num_errors = 0;
	int num_checks = 0;
	// Channel side answers combinationally with a bank and slot tag
	assign wrd = {wreq.bank, 4'ha, wreq.slot};
	timer_xy_conn i_timer_xy_conn (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'h1), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_cap_pin(pin), .i_x_counter(xcnt), .i_x_clock_source(xsrc),
		.i_y_clock_source(ysrc), .i_y_match_a(ymatch), .i_win_rdata(wrd),
		.o_win_req(wreq), .o_capture_arm(arm), .o_x_clock_select(xsel),
		.o_y_clock_select(ysel), .o_cascade_16(casc), .o_x_cm_count(cmc),
		.o_x_count_pulse(cpulse), .o_irq(irq));
	cap_src i_cap_src (.i_mclk(mclk), .i_go(go), .i_width(width), .o_pin(pin));
	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Request held until pready is seen high; nothing released earlier
	task automatic apb(input logic wr, input logic [19:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'h1;
		// No answer delay assumed; only the watchdog ends a hung wait
		do begin
			@(posedge mclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = 32'(pslverr);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdchk(input string nm, input logic [19:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h00);
		chk(nm, rd, {24'h000000, e});
	endtask
	task automatic pulse(input logic [7:0] c, input logic [7:0] w);
		@(posedge mclk);
		xcnt <= c;
		width <= w;
		go <= 1'h1;
		@(posedge mclk);
		go <= 1'h0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		cyc(20000);
		num_errors++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		rst_n = 1'h0;
		{psel, penable, pwrite, ymatch, go} = 5'h00;
		{paddr, pwdata, xcnt, width, xsrc, ysrc} = 74'h0;
		cyc(10);
		rst_n <= 1'h1;
		foreach (ROWS[i]) begin
			apb(ROWS[i].wr, ROWS[i].a, ROWS[i].wd);
			chk("pslverr", er, 32'(ROWS[i].err));
			if (!ROWS[i].wr) chk("prdata", rd, 32'(ROWS[i].rd));
		end
		apb(1'h1, 20'h3ffc4, 8'h5c);
		chk("win write", {19'h0, wreq.bank, wreq.slot, wreq.write, wreq.wdata}, 32'h35c);
		$display("register table done");
		apb(1'h1, A_CAP, 8'h10);
		@(negedge mclk);
		chk("arm unread", 32'(arm), 32'h0);
		pulse(8'h11, 8'd40);
		rdchk("ctrl", A_CAP, 8'h00);
		apb(1'h1, A_CAP, 8'h10);
		@(negedge mclk);
		chk("arm set", 32'(arm), 32'h1);
		cyc(40);
		chk("early fall", 32'(arm), 32'h1);
		rdchk("rise early", A_RISE, 8'h00);
		pulse(8'h3c, 8'd20);
		cyc(10);
		xcnt <= 8'h5a;
		cyc(20);
		rdchk("rise", A_RISE, 8'h3c);
		rdchk("fall", A_FALL, 8'h5a);
		chk("arm cleared", 32'(arm), 32'h0);
		chk("irq masked", 32'(irq), 32'h0);
		rdchk("status", A_STAT, 8'h03);
		apb(1'h1, A_MASK, 8'h03);
		cyc(2);
		chk("irq", 32'(irq), 32'h1);
		apb(1'h1, A_STAT, 8'h03);
		cyc(2);
		chk("irq clear", 32'(irq), 32'h0);
		pulse(8'h77, 8'd10);
		cyc(15);
		rdchk("one pair", A_RISE, 8'h3c);
		$display("capture done");
		rdchk("ctrl again", A_CAP, 8'h00);
		apb(1'h1, A_CAP, 8'h10);
		// Rise lands inside a capture read; count moves so a late store shows
		fork
			begin
				apb(1'h0, A_RISE, 8'h00);
			end
			begin
				pulse(8'h44, 8'd6);
				@(posedge mclk);
				xcnt <= 8'h45;
			end
		join
		chk("read old", rd, 32'h3c);
		cyc(10);
		rdchk("rise late", A_RISE, 8'h45);
		rdchk("fall late", A_FALL, 8'h45);
		chk("arm cleared again", 32'(arm), 32'h0);
		$display("read postpone done");
		ysrc <= CKS_CASCADE;
		apb(1'h1, A_XY, 8'h10);
		cyc(2);
		chk("cascade", {30'h0, casc, cmc}, 32'h2);
		xsrc <= CKS_CASCADE;
		apb(1'h1, A_XY, 8'h20);
		cyc(2);
		chk("cm count", {29'h0, casc, cmc, xsel}, 32'h3);
		ymatch <= 1'h1;
		@(posedge mclk);
		ymatch <= 1'h0;
		@(negedge mclk);
		chk("count pulse", 32'(cpulse), 32'h1);
		@(negedge mclk);
		chk("pulse end", 32'(cpulse), 32'h0);
		$display("cascade done");
		@(posedge mclk);
		rst_n <= 1'h0;
		cyc(3);
		rst_n <= 1'h1;
		@(negedge mclk);
		chk("reset outs", {27'h0, arm, xsel, ysel, cmc, irq}, 32'h0);
		foreach (RST_A[i]) rdchk("reset value", RST_A[i], 8'h00);
		$display("reset done");
		conclude();
	end
endmodule

/* src/pulse_capture.sv */
// One-shot rise/fall capture of the channel X count
module pulse_capture (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_arm,
	input wire logic i_cap_pin,
	input wire logic [7:0] i_count,
	input wire logic i_read_hold,
	output txy_pkg::capture_t o_cap
);
	import txy_pkg::*;

	cap_state_t state_reg;
	logic pin_prev_reg;
	logic rise_pend_reg;
	logic fall_pend_reg;
	logic rise_edge;
	logic fall_edge;
	logic rise_eff;
	logic fall_eff;

	assign rise_edge = i_cap_pin & ~pin_prev_reg;
	assign fall_edge = ~i_cap_pin & pin_prev_reg;
	// Edge during a capture register read waits one cycle
	assign rise_eff = (rise_edge & ~i_read_hold) | rise_pend_reg; // R13
	assign fall_eff = (fall_edge & ~i_read_hold) | fall_pend_reg; // R13

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pin_prev_reg <= 1'b0;
			rise_pend_reg <= 1'b0;
			fall_pend_reg <= 1'b0;
		end else begin
			pin_prev_reg <= i_cap_pin;
			rise_pend_reg <= i_arm & rise_edge & i_read_hold; // R13
			fall_pend_reg <= i_arm & fall_edge & i_read_hold; // R13
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg <= CAP_WAIT_RISE;
			o_cap <= '0;
		end else begin
			o_cap.rise_stb <= 1'b0;
			o_cap.pair_stb <= 1'b0;
			if (!i_arm) begin
				state_reg <= CAP_WAIT_RISE;
			end else begin
				unique case (state_reg)
					// Falls before the first rise are ignored
					CAP_WAIT_RISE: if (rise_eff) begin // R09
						o_cap.rise_val <= i_count; // R01
						o_cap.rise_stb <= 1'b1;
						state_reg <= CAP_WAIT_FALL;
					end
					CAP_WAIT_FALL: if (fall_eff) begin
						o_cap.fall_val <= i_count; // R01
						o_cap.pair_stb <= 1'b1;
						state_reg <= CAP_DONE; // R02
					end
					CAP_DONE: state_reg <= CAP_DONE;
					default: state_reg <= CAP_WAIT_RISE;
				endcase
			end
		end
	end

	rise_store_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R01
		(i_arm && state_reg == CAP_WAIT_RISE && rise_eff)
		|=> (o_cap.rise_val == $past(i_count)) && state_reg == CAP_WAIT_FALL)
		else $error("rise capture not stored");

	early_fall_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
		(state_reg == CAP_WAIT_RISE && !rise_eff) |=> $stable(o_cap.fall_val)
		&& !o_cap.pair_stb)
		else $error("fall captured before rise");

	read_delay_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R13
		(i_arm && state_reg == CAP_WAIT_RISE && rise_edge && i_read_hold && !rise_pend_reg)
		|=> !o_cap.rise_stb ##1 o_cap.rise_stb)
		else $error("postponed capture not one cycle late");
endmodule

/* src/timer_xy_conn.sv */
// Timer X/Y connection logic: capture control, bank window and clock select
// Function
// R01 - While armed, the X count is stored on a capture rise, then on the next fall.
// R02 - After a rise then a fall has been captured, hardware clears the arm bit.
// R03 - Arm becomes 1 only on a write of 1 after reading it as 0, and resets to 0.
// R04 - Software keeps the reserved bits of the three connection registers at zero.
// R05 - With bank select 0 the shared window reaches the channel X registers.
// R06 - With bank select 1 the shared window reaches the channel Y registers.
// R07 - Window slots map to X or Y registers by the fixed per-bank order.
// R08 - The clock control register holds X select at bit 5 and Y select at bit 4.
// R09 - After arming, a fall before any rise is ignored.
// R10 - Rise and fall capture registers are 8-bit, read-only and reset to zero.
// R11 - Y source 100 with Y select set joins Y and X into one 16-bit counter.
// R12 - X source 100 with X select set counts Y compare-match A events on X.
// R13 - A capture edge during a capture register read is postponed one cycle.
module timer_xy_conn (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [txy_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_cap_pin,
	input wire logic [7:0] i_x_counter,
	input wire logic [2:0] i_x_clock_source,
	input wire logic [2:0] i_y_clock_source,
	input wire logic i_y_match_a,
	input wire logic [7:0] i_win_rdata,
	output txy_pkg::win_req_t o_win_req,
	output logic o_capture_arm,
	output logic o_x_clock_select,
	output logic o_y_clock_select,
	output logic o_cascade_16,
	output logic o_x_cm_count,
	output logic o_x_count_pulse,
	output logic o_irq
);
	import txy_pkg::*;

	bus_state_t bus_reg;
	capture_t cap;
	logic bank_reg;
	logic arm_read0_reg;
	logic [IRQ_W-1:0] stat_reg;
	logic [IRQ_W-1:0] mask_reg;
	logic [IRQ_W-1:0] stat_next;
	logic [IRQ_W-1:0] events;

	logic [IDX_W-1:0] idx;
	logic [2:0] slot;
	logic in_win;
	logic hit_rise;
	logic hit_fall;
	logic hit_local_cap;
	logic hit_fwd;
	logic hit_own;
	logic access;
	logic wr_en;
	logic rd_en;
	logic read_hold;
	logic [7:0] wbyte;
	logic [7:0] local_rdata;

	// Decode
	assign idx = i_paddr[ADDR_W-1:2];
	assign slot = idx[2:0];
	assign in_win = (idx >= IDX_WIN_FIRST) && (idx <= IDX_WIN_LAST);
	// Capture registers live only in the channel X bank
	assign hit_rise = in_win && !bank_reg && slot == SLOT_RISE; // R07
	assign hit_fall = in_win && !bank_reg && slot == SLOT_FALL; // R07
	assign hit_local_cap = hit_rise || hit_fall;
	// Y bank has five slots; the rest are holes
	assign hit_fwd = in_win && !hit_local_cap && (!bank_reg || slot <= SLOT_Y_LAST); // R07
	assign hit_own = (idx == IDX_CAP_CTRL) || (idx == IDX_BANK_SEL) || (idx == IDX_XY_CLK)
		|| (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);

	assign access = i_psel && i_penable && bus_reg == BUS_IDLE;
	assign wr_en = access && i_pwrite && i_pstrb[0] && hit_own;
	assign rd_en = access && !i_pwrite;
	assign wbyte = i_pwdata[7:0];
	// Held over the whole transfer so a capture edge never races the read
	assign read_hold = i_psel && !i_pwrite && hit_local_cap; // R13

	pulse_capture u_capture (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_arm(o_capture_arm),
		.i_cap_pin(i_cap_pin),
		.i_count(i_x_counter),
		.i_read_hold(read_hold),
		.o_cap(cap)
	);

	always_comb begin
		local_rdata = 8'h00;
		if (hit_rise) begin
			local_rdata = cap.rise_val; // R10
		end else if (hit_fall) begin
			local_rdata = cap.fall_val; // R10
		end else if (idx == IDX_CAP_CTRL) begin
			local_rdata[ARM_BIT] = o_capture_arm;
		end else if (idx == IDX_BANK_SEL) begin
			local_rdata[BANK_BIT] = bank_reg;
		end else if (idx == IDX_XY_CLK) begin
			local_rdata[XCS_BIT] = o_x_clock_select;
			local_rdata[YCS_BIT] = o_y_clock_select;
		end else if (idx == IDX_IRQ_STAT) begin
			local_rdata[IRQ_W-1:0] = stat_reg;
		end else if (idx == IDX_IRQ_MASK) begin
			local_rdata[IRQ_W-1:0] = mask_reg;
		end
	end

	// Bus answer: one wait state locally, two when forwarded to a channel
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			bus_reg <= BUS_IDLE;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_win_req <= '0;
		end else begin
			o_win_req.valid <= 1'b0;
			unique case (bus_reg)
				BUS_IDLE: if (i_psel && i_penable) begin
					if (hit_fwd) begin
						o_win_req.valid <= 1'b1;
						o_win_req.bank <= bank_reg; // R05 R06
						o_win_req.slot <= slot; // R07
						o_win_req.write <= i_pwrite && i_pstrb[0];
						o_win_req.wdata <= wbyte;
						bus_reg <= BUS_FWD;
					end else begin
						o_pready <= 1'b1;
						o_pslverr <= !(hit_own || hit_local_cap);
						o_prdata <= {24'h00_0000, i_pwrite ? 8'h00 : local_rdata};
						bus_reg <= BUS_DONE;
					end
				end
				BUS_FWD: begin
					o_pready <= 1'b1;
					o_pslverr <= 1'b0;
					o_prdata <= {24'h00_0000, o_win_req.write ? 8'h00 : i_win_rdata};
					bus_reg <= BUS_DONE;
				end
				BUS_DONE: begin
					o_pready <= 1'b0;
					o_pslverr <= 1'b0;
					bus_reg <= BUS_IDLE;
				end
			endcase
		end
	end

	// Bank select
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			bank_reg <= REG_RESET[BANK_BIT]; // R05
		end else if (wr_en && idx == IDX_BANK_SEL) begin
			bank_reg <= wbyte[BANK_BIT]; // R06
		end
	end

	// Clock selects
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_x_clock_select <= REG_RESET[XCS_BIT]; // R08
			o_y_clock_select <= REG_RESET[YCS_BIT]; // R08
		end else if (wr_en && idx == IDX_XY_CLK) begin
			o_x_clock_select <= wbyte[XCS_BIT]; // R08
			o_y_clock_select <= wbyte[YCS_BIT]; // R08
		end
	end

	// Capture arm: a read of 0 opens the way for one write of 1
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_capture_arm <= REG_RESET[ARM_BIT]; // R03
			arm_read0_reg <= 1'b0;
		end else begin
			if (rd_en && idx == IDX_CAP_CTRL && !o_capture_arm) begin
				arm_read0_reg <= 1'b1; // R03
			end else if (wr_en && idx == IDX_CAP_CTRL) begin
				arm_read0_reg <= 1'b0;
			end
			if (cap.pair_stb) begin
				o_capture_arm <= 1'b0; // R02
			end else if (wr_en && idx == IDX_CAP_CTRL) begin
				if (!wbyte[ARM_BIT]) begin
					o_capture_arm <= 1'b0;
				end else if (arm_read0_reg) begin
					o_capture_arm <= 1'b1; // R03
				end
			end
		end
	end

	// Cascade modes; X count pulse is one cycle behind the Y match
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_cascade_16 <= 1'b0;
			o_x_cm_count <= 1'b0;
			o_x_count_pulse <= 1'b0;
		end else begin
			o_cascade_16 <= i_y_clock_source == CKS_CASCADE && o_y_clock_select; // R11
			o_x_cm_count <= i_x_clock_source == CKS_CASCADE && o_x_clock_select; // R12
			o_x_count_pulse <= i_x_clock_source == CKS_CASCADE && o_x_clock_select
				&& i_y_match_a; // R12
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_comb begin
		events = '0;
		events[IRQ_RISE] = cap.rise_stb;
		events[IRQ_PAIR] = cap.pair_stb;
		stat_next = stat_reg;
		if (wr_en && idx == IDX_IRQ_STAT) begin
			stat_next = stat_reg & ~wbyte[IRQ_W-1:0];
		end
		stat_next = stat_next | events;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			stat_reg <= IRQ_RESET;
			mask_reg <= IRQ_RESET;
			o_irq <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			if (wr_en && idx == IDX_IRQ_MASK) begin
				mask_reg <= wbyte[IRQ_W-1:0];
			end
			o_irq <= |(stat_next & mask_reg);
		end
	end

	sequence local_take_s;
		bus_reg == BUS_IDLE && i_psel && i_penable && !hit_fwd;
	endsequence

	sequence fwd_take_s;
		bus_reg == BUS_IDLE && i_psel && i_penable && hit_fwd;
	endsequence

	sequence answer_s;
		o_pready ##1 !o_pready;
	endsequence

	arm_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R02
		cap.pair_stb |=> !o_capture_arm)
		else $error("arm not cleared after capture pair");

	arm_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R03
		$rose(o_capture_arm) |-> $past(arm_read0_reg) && $past(wr_en))
		else $error("arm set without prior read of zero");

	bank_x_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R05
		(fwd_take_s and (!bank_reg)) |=> o_win_req.valid && !o_win_req.bank)
		else $error("window did not reach channel X");

	bank_y_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R06
		(fwd_take_s and bank_reg) |=> o_win_req.valid && o_win_req.bank
		&& o_win_req.slot <= SLOT_Y_LAST)
		else $error("window did not reach channel Y");

	local_answer_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
		local_take_s |=> answer_s)
		else $error("local access answer timing wrong");

	fwd_answer_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
		fwd_take_s |=> !o_pready ##1 answer_s)
		else $error("forwarded access answer timing wrong");

	clock_bits_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R08
		(wr_en && idx == IDX_XY_CLK) |=> o_x_clock_select == $past(wbyte[XCS_BIT])
		&& o_y_clock_select == $past(wbyte[YCS_BIT]))
		else $error("clock select bits not stored");

	cap_readonly_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R10
		(access && i_pwrite && hit_local_cap && !cap.rise_stb && !cap.pair_stb)
		|=> $stable(cap.rise_val) && $stable(cap.fall_val))
		else $error("capture register changed by write");

	cascade16_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R11
		(i_y_clock_source == CKS_CASCADE && o_y_clock_select) |=> o_cascade_16)
		else $error("16-bit cascade not flagged");

	cm_count_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R12
		(i_x_clock_source == CKS_CASCADE && o_x_clock_select && i_y_match_a)
		|=> o_x_count_pulse && o_x_cm_count)
		else $error("X count pulse missing on Y match");
endmodule

/* src/txy_pkg.sv */
// Shared constants and types for the timer X/Y capture and bank select block
package txy_pkg;

	localparam int ADDR_W = 20;
	localparam int IDX_W = 18;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_WIN_FIRST = 18'h0fff0;
	localparam logic [IDX_W-1:0] IDX_WIN_LAST = 18'h0fff7;
	localparam logic [IDX_W-1:0] IDX_CAP_CTRL = 18'h0fff8;
	localparam logic [IDX_W-1:0] IDX_BANK_SEL = 18'h0fff9;
	localparam logic [IDX_W-1:0] IDX_XY_CLK = 18'h0fffa;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 18'h0fffb;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 18'h0fffc;

	// Window slots
	localparam logic [2:0] SLOT_RISE = 3'h2;
	localparam logic [2:0] SLOT_FALL = 3'h3;
	localparam logic [2:0] SLOT_Y_LAST = 3'h4;

	// Field positions
	localparam int ARM_BIT = 4;
	localparam int BANK_BIT = 7;
	localparam int XCS_BIT = 5;
	localparam int YCS_BIT = 4;
	localparam int IRQ_RISE = 0;
	localparam int IRQ_PAIR = 1;
	localparam int IRQ_W = 2;

	localparam logic [2:0] CKS_CASCADE = 3'h4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CAP_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	typedef struct packed {
		logic valid;
		logic bank;
		logic [2:0] slot;
		logic write;
		logic [7:0] wdata;
	} win_req_t;

	typedef struct packed {
		logic rise_stb;
		logic pair_stb;
		logic [7:0] rise_val;
		logic [7:0] fall_val;
	} capture_t;

	typedef enum logic [2:0] {
		CAP_WAIT_RISE = 3'b001,
		CAP_WAIT_FALL = 3'b010,
		CAP_DONE = 3'b100
	} cap_state_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_FWD = 3'b010,
		BUS_DONE = 3'b100
	} bus_state_t;

endpackage
